// ===== core/psv_pkg.sv
// Constants for program space vectoring: address map and widths.
// Assumes a 13-bit program counter over an 8K x 16 program store.
package psv_pkg;
  localparam int          PSV_PC_W       = 13;
  localparam int          PSV_WORD_W     = 16;
  localparam int          PSV_DEPTH      = 8192;
  localparam logic [12:0] PSV_RESET_VEC  = 13'h0000;
  localparam logic [12:0] PSV_IRQ_VEC    = 13'h0008;
  localparam logic [12:0] PSV_RSV_LO     = 13'h0004;
  localparam logic [12:0] PSV_RSV_HI     = 13'h0007;
  localparam logic [12:0] PSV_USER_LO    = 13'h0010;
  localparam logic [12:0] PSV_USER_HI    = 13'h1ffe;
  localparam logic [12:0] PSV_LAST_ADDR  = 13'h1fff;
  localparam int          PSV_STACK_D    = 8;
  localparam logic [2:0]  PSV_SP_RESET   = 3'h0;
  localparam logic [15:0] PSV_SUM_RESET  = 16'h0000;
endpackage

// ===== core/psv_sum_if.sv
// Carries checksum accumulation between the vectoring core and its summer.
// Assumes both ends share i_clock.
`timescale 1ns/1ns
interface psv_sum_if;
  logic        valid;
  logic        clear;
  logic [12:0] addr;
  logic [15:0] data;
  logic [15:0] sum;
  modport core (output valid, output clear, output addr, output data, input sum);
  modport summer (input valid, input clear, input addr, input data, output sum);
endinterface

// ===== core/psv_sum.sv
// Checksum accumulator over fetched program words.
// Assumes one word per valid cycle, same clock as the core.
`timescale 1ns/1ns
module psv_sum
  import psv_pkg::*;
(
  // Clock and reset
  input  wire logic i_clock,
  input  wire logic i_arst_n,
  // Word stream
  psv_sum_if.summer sum_port
);
  logic [15:0] sum_q;
  logic [15:0] sum_d;
  logic        excl;

  always_comb
  begin
    // Reserved words and the final word do not count
    excl  = ((sum_port.addr >= PSV_RSV_LO) && (sum_port.addr <= PSV_RSV_HI))
            || (sum_port.addr == PSV_LAST_ADDR);
    sum_d = sum_q;
    if (sum_port.clear)
      sum_d = PSV_SUM_RESET;
    else if (sum_port.valid && !excl)
      sum_d = sum_q + sum_port.data;
  end

  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
      sum_q <= PSV_SUM_RESET;
    else
      sum_q <= sum_d;
  end

  assign sum_port.sum = sum_q;
endmodule // psv_sum

// ===== core/psv_core.sv
// Program counter sequencing, reset and interrupt vectoring, return stack.
// Assumes fetch logic gives one step command per cycle; memory has no wait.
// What this block does
// - Addresses 8192 sixteen-bit words through a 13-bit program counter.
// - Power-on or watchdog reset loads counter with zero, registers to defaults; watchdog keeps the stack slots.
// - Interrupt entry pushes counter onto stack, then jumps to word eight.
// - Checksum skips words four to seven and the last word.
`timescale 1ns/1ns
module psv_core
  import psv_pkg::*;
#(
  parameter int STACK_D = PSV_STACK_D
)
(
  // Clock and reset
  input  wire logic                  i_clock,
  input  wire logic                  i_arst_n,
  input  wire logic                  i_wdt_reset,
  // Fetch commands
  input  wire logic                  i_advance,
  input  wire logic                  i_jump,
  input  wire logic [PSV_PC_W-1:0]   i_jump_addr,
  input  wire logic                  i_irq_take,
  input  wire logic                  i_iret,
  // Program memory
  input  wire logic [PSV_WORD_W-1:0] i_mem_data,
  // Status
  output logic [PSV_PC_W-1:0]        o_pc,
  output logic                       o_fetch_valid,
  output logic                       o_in_irq,
  output logic                       o_rsv_fault,
  output logic [PSV_WORD_W-1:0]      o_checksum
);
  typedef enum logic [1:0] {PSV_RST, PSV_RUN} psv_state_e;

  psv_state_e                 state_q;
  psv_state_e                 state_d;
  logic [PSV_PC_W-1:0]        pc_q;
  logic [PSV_PC_W-1:0]        pc_d;
  logic [PSV_PC_W-1:0]        stk_q [STACK_D];
  logic [PSV_PC_W-1:0]        stk_d [STACK_D];
  logic [2:0]                 sp_q;
  logic [2:0]                 sp_d;
  logic                       fv_q;
  logic                       fv_d;
  logic                       fault_q;
  logic                       fault_d;
  logic [2:0]                 sp_top;
  logic                       push;
  logic                       pop;
  logic                       restart;
  // Occupancy needs one bit more than the pointer
  logic [3:0]                 depth_q;
  logic [3:0]                 depth_d;
  logic                       in_irq_q;
  logic                       in_irq_d;

  psv_sum_if sum_bus ();

  psv_sum u_sum
  (
    .i_clock  (i_clock),
    .i_arst_n (i_arst_n),
    .sum_port (sum_bus.summer)
  );

  assign sp_top = sp_q - 3'h1;

  always_comb
  begin
    state_d = state_q;
    pc_d    = pc_q;
    sp_d    = sp_q;
    fv_d    = 1'b0;
    fault_d = fault_q;
    push    = 1'b0;
    pop     = 1'b0;
    restart = 1'b0;
    case (state_q)
      PSV_RST:
      begin
        // One idle cycle after reset so the first fetch is word zero
        pc_d    = PSV_RESET_VEC;
        fv_d    = 1'b1;
        state_d = PSV_RUN;
      end
      PSV_RUN:
      begin
        if (i_wdt_reset)
        begin
          pc_d    = PSV_RESET_VEC;
          sp_d    = PSV_SP_RESET;
          fault_d = 1'b0;
          restart = 1'b1;
          state_d = PSV_RST;
        end
        else if (i_irq_take)
        begin
          push = 1'b1;
          sp_d = sp_q + 3'h1;
          pc_d = PSV_IRQ_VEC;
          fv_d = 1'b1;
        end
        else if (i_iret)
        begin
          pc_d = stk_q[sp_top];
          sp_d = sp_top;
          pop  = 1'b1;
          fv_d = 1'b1;
        end
        else if (i_jump)
        begin
          pc_d = i_jump_addr;
          fv_d = 1'b1;
        end
        else if (i_advance)
        begin
          // Counter wraps at 13 bits; no store beyond 8K words
          pc_d = pc_q + 13'h0001;
          fv_d = 1'b1;
        end
        // Sticky flag: the image strayed into the reserved words
        if (fv_d && (pc_d >= PSV_RSV_LO) && (pc_d <= PSV_RSV_HI))
          fault_d = 1'b1;
      end
      default:
        state_d = PSV_RST;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      state_q <= PSV_RST;
      pc_q    <= PSV_RESET_VEC;
      sp_q    <= PSV_SP_RESET;
      fv_q    <= 1'b0;
      fault_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      pc_q    <= pc_d;
      sp_q    <= sp_d;
      fv_q    <= fv_d;
      fault_q <= fault_d;
    end
  end

  // One slot per entry; only the slot under the pointer takes the saved counter
  for (genvar g = 0; g < STACK_D; g++)
  begin : g_stack
    always_comb
    begin
      stk_d[g] = stk_q[g];
      if (push && (sp_q == 3'(g)))
        stk_d[g] = pc_q;
    end

    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
      if (!i_arst_n)
        stk_q[g] <= '0;
      else
        stk_q[g] <= stk_d[g];
    end
  end

  // Occupancy kept apart from the pointer: eight pushes wrap the 3-bit pointer to zero,
  // which would read as an empty stack while it is full
  always_comb
  begin
    depth_d = depth_q;
    if (restart)
      depth_d = 4'h0;
    else if (push)
    begin
      // Overflow wraps the stack silently; the count only saturates
      if (depth_q != 4'(STACK_D))
        depth_d = depth_q + 4'h1;
    end
    else if (pop)
    begin
      if (depth_q != 4'h0)
        depth_d = depth_q - 4'h1;
    end
    in_irq_d = (depth_d != 4'h0);
  end

  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      depth_q  <= 4'h0;
      in_irq_q <= 1'b0;
    end
    else
    begin
      depth_q  <= depth_d;
      in_irq_q <= in_irq_d;
    end
  end

  // Fetched word of the current counter feeds the checksum
  assign sum_bus.valid = fv_q;
  assign sum_bus.clear = (state_q == PSV_RST);
  assign sum_bus.addr  = pc_q;
  assign sum_bus.data  = i_mem_data;

  assign o_pc          = pc_q;
  assign o_fetch_valid = fv_q;
  assign o_in_irq      = in_irq_q;
  assign o_rsv_fault   = fault_q;
  assign o_checksum    = sum_bus.sum;
endmodule // psv_core

// ===== testbench/psv_mem_model.sv
// Program store model: combinational read.
// Assumes the fetch address holds for the read cycle.
`timescale 1ns/1ns
module psv_mem_model (
  // Fetch address
  input  wire logic [12:0] i_addr,
  // Read word
  output logic      [15:0] o_data
);
  // Word zero reads zero, so a restart fetch adds nothing
  assign o_data = {i_addr[2:0], i_addr};
endmodule // psv_mem_model

// ===== testbench/psv_core_monitor.sv
// Port checker bound into psv_core.
// Assumes no commands in reset cycles.
`timescale 1ns/1ns
module psv_core_monitor (
  // Clock and reset
  input wire logic        i_clock,
  input wire logic        i_arst_n,
  // Commands
  input wire logic        i_wdt_reset,
  input wire logic        i_advance,
  input wire logic        i_jump,
  input wire logic        i_irq_take,
  input wire logic        i_iret,
  input wire logic [15:0] i_mem_data,
  // Results
  input wire logic        o_fetch_valid,
  input wire logic        o_in_irq,
  input wire logic        o_rsv_fault,
  input wire logic [12:0] o_pc,
  input wire logic [15:0] o_checksum
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);
  logic [12:0] sv_q;
  // Outermost entry only; nesting is left to the bench
  always_ff @(posedge i_clock)
    if (i_irq_take && !o_in_irq) sv_q <= o_pc;
  property p_adv;
    i_advance && !i_jump && !i_irq_take && !i_iret && !i_wdt_reset
      |=> o_pc == $past(o_pc) + 13'h1;
  endproperty
  a_adv: assert property (p_adv) else $error("pc step");
  property p_wdt;
    i_wdt_reset |=> o_pc == 13'h0 && !o_in_irq ##1 o_fetch_valid && o_pc == 13'h0;
  endproperty
  a_wdt: assert property (p_wdt) else $error("restart");
  property p_irq;
    i_irq_take && !i_wdt_reset |=> o_pc == 13'h8 && o_in_irq && o_fetch_valid;
  endproperty
  a_irq: assert property (p_irq) else $error("entry");
  property p_ret;
    i_iret && !i_irq_take && !i_wdt_reset |=> !o_in_irq |-> o_pc == sv_q;
  endproperty
  a_ret: assert property (p_ret) else $error("return");
  property p_sum;
    o_fetch_valid && !i_wdt_reset && !$past(i_wdt_reset, 2)
      |=> o_checksum == $past(o_checksum)
      + ($past(o_pc) inside {[13'h4:13'h7], 13'h1fff} ? 16'h0 : $past(i_mem_data));
  endproperty
  a_sum: assert property (p_sum) else $error("checksum");
  property p_flt;
    o_fetch_valid && (o_pc inside {[13'h4:13'h7]}) |-> o_rsv_fault;
  endproperty
  a_flt: assert property (p_flt) else $error("reserved");
endmodule // psv_core_monitor
bind psv_core psv_core_monitor u_psv_core_monitor
(
  .i_clock       (i_clock),
  .i_arst_n      (i_arst_n),
  .i_wdt_reset   (i_wdt_reset),
  .i_advance     (i_advance),
  .i_jump        (i_jump),
  .i_irq_take    (i_irq_take),
  .i_iret        (i_iret),
  .i_mem_data    (i_mem_data),
  .o_fetch_valid (o_fetch_valid),
  .o_in_irq      (o_in_irq),
  .o_rsv_fault   (o_rsv_fault),
  .o_pc          (o_pc),
  .o_checksum    (o_checksum)
);

// ===== testbench/psv_core_tb_top.sv
// Bench: LFSR commands into psv_core against a queue model.
// Assumes the memory model word {addr[2:0], addr}.
`timescale 1ns/1ns
module psv_core_tb_top;
  logic i_clock, i_arst_n, i_wdt_reset, i_advance, i_jump, i_irq_take, i_iret;
  logic o_fetch_valid, o_in_irq, o_rsv_fault, f, pp, pend, flt;
  logic [4:0] c;
  logic [12:0] i_jump_addr, o_pc;
  logic [15:0] i_mem_data, o_checksum, ev;
  logic [16:0] r = 17'h17e57;
  int n_mismatch, cmp_count, cyc, pc, sum, stk[$];
  psv_core u_psv_core
  (
    .i_clock       (i_clock),
    .i_arst_n      (i_arst_n),
    .i_wdt_reset   (i_wdt_reset),
    .i_advance     (i_advance),
    .i_jump        (i_jump),
    .i_jump_addr   (i_jump_addr),
    .i_irq_take    (i_irq_take),
    .i_iret        (i_iret),
    .i_mem_data    (i_mem_data),
    .o_pc          (o_pc),
    .o_fetch_valid (o_fetch_valid),
    .o_in_irq      (o_in_irq),
    .o_rsv_fault   (o_rsv_fault),
    .o_checksum    (o_checksum)
  );
  psv_mem_model u_psv_mem_model (.i_addr(o_pc), .o_data(i_mem_data));
  function automatic logic [16:0] lfsr(logic [16:0] x);
    return {x[15:0], x[16] ^ x[13]};
  endfunction
  task automatic cmp(input logic [15:0] e, g);
    cmp_count++;
    if (e !== g)
      n_mismatch++;
    if (e !== g)
      $display("mismatch %0t %h %h", $time, e, g);
  endtask
  task automatic wrap_up;
    if (n_mismatch == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end
  always @(posedge i_clock)
    if (++cyc > 4000)
    begin
      n_mismatch++;
      wrap_up();
    end
  initial
  begin
    {i_arst_n, i_wdt_reset, i_advance, i_jump, i_irq_take, i_iret, pend, flt, i_jump_addr} = 21'h0;
    repeat (10) @(posedge i_clock);
    @(negedge i_clock) i_arst_n = 1'b1;
    repeat (3) @(posedge i_clock);
    for (int k = 1; k < 3000; k++)
    begin
      r = lfsr(r);
      // Stack kept within depth: overflow and empty return are undefined
      // Word zero and the last user word never advance; outside the restart and stray steps they jump into the user area; every
      // 600th step strays on purpose into the reserved or last word
      c = pend ? 5'h0 : k % 600 == 0 ? 5'h10
        : pc == 0 || pc == 8190 || k % 600 == 300 ? 5'h02
        : {1'b0, &r[5:3] && stk.size() < 8, &r[7:6] && stk.size() > 0, &r[2:1], r[0]};
      @(negedge i_clock);
      {i_wdt_reset, i_irq_take, i_iret, i_jump, i_advance} = c;
      i_jump_addr = k % 600 != 300 ? 13'(16 + r[16:4] % 8175)
        : k % 1200 == 300 ? 13'h1fff : {11'h001, r[2:1]};
      pp = pend;
      pend = c[4];
      f = !c[4] && (c != 5'h0 || pp);
      if (c[4])
        stk.delete();
      if (c[3])
        stk.push_back(pc);
      sum = c[4] ? 0 : sum;
      pc = c[4] ? 0 : c[3] ? 8 : c[2] ? stk.pop_back()
        : c[1] ? i_jump_addr : c[0] ? (pc + 1) % 8192 : pc;
      flt = !c[4] && (flt || (f && pc inside {[4:7]}));
      ev = {f, stk.size() != 0, flt, pc[12:0]};
      @(posedge i_clock);
      #1;
      cmp(ev, {o_fetch_valid, o_in_irq, o_rsv_fault, o_pc});
      if (!c[4] && !pp)
        cmp(sum[15:0], o_checksum);
      if (f && !(pc inside {[4:7], 8191}))
        sum = (sum + {pc[2:0], pc[12:0]}) % 65536;
    end
    wrap_up();
  end
endmodule // psv_core_tb_top
